//--- pkg/ctp_pkg.sv
// package with register map, field layout and timing constants
package ctp_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] CTP_TMR_CTRL_ADDR = 8'h05;
  localparam logic [7:0] CTP_OVP_CTRL_ADDR = 8'h06;
  localparam logic [7:0] CTP_TMR_RESET     = 8'hb8;
  localparam logic [7:0] CTP_OVP_RESET     = 8'he0;

  // field positions, register 0x05
  localparam int CTP_SLOW_BIT  = 7;
  localparam int CTP_LIM_HI    = 6;
  localparam int CTP_LIM_LO    = 5;
  localparam int CTP_DISC_BIT  = 4;
  localparam int CTP_THEN_BIT  = 3;
  // field positions, register 0x06
  localparam int CTP_OVP_HI    = 7;
  localparam int CTP_OVP_LO    = 5;
  localparam int CTP_DPREL_BIT = 4;
  localparam int CTP_BDET_BIT  = 3;
  localparam int CTP_TEST_BIT  = 2;

  // ************************************************************
  // encodings
  // ************************************************************
  localparam logic [1:0] CTP_LIM_075H = 2'h0;
  localparam logic [1:0] CTP_LIM_6H   = 2'h1;
  localparam logic [1:0] CTP_LIM_9H   = 2'h2;
  localparam logic [1:0] CTP_LIM_OFF  = 2'h3;
  localparam logic [3:0] CTP_FAULT_NONE  = 4'h0;
  localparam logic [3:0] CTP_FAULT_TSHUT = 4'h6;
  localparam logic [3:0] CTP_FAULT_TIMER = 4'h7;
  localparam logic [2:0] CTP_TH_OPEN     = 3'h7;

  // ************************************************************
  // timing
  // ************************************************************
  localparam longint CTP_CLK_HZ       = 10000000;
  localparam longint CTP_PULSE_NS     = 256000;
  localparam longint CTP_PULSE_CYC    = CTP_PULSE_NS * CTP_CLK_HZ / 1000000000;
  localparam longint CTP_T075_MIN     = 45;
  localparam longint CTP_T6_MIN       = 360;
  localparam longint CTP_T9_MIN       = 540;
  localparam longint CTP_CYC_PER_MIN  = 60 * CTP_CLK_HZ;

  // carrier for regulation loop status
  typedef struct packed {
    logic thermal;
    logic input_v;
    logic power_path;
  } ctp_loops_t;

endpackage : ctp_pkg

//--- hw/ctp_pulse.sv
// fixed-length pulse generator fired by a one-cycle trigger
`timescale 1ns/1ps
module ctp_pulse
  import ctp_pkg::*;
#(
  parameter int unsigned LEN = 2560
) (
  input  wire logic clock_in,
  input  wire logic sys_rst_in,
  input  wire logic fire_in,
  output logic      pulse_out
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  // load on trigger, count down to zero
  always_comb begin
    cnt_next = cnt_reg;
    if (fire_in) begin
      cnt_next = LEN;
    end else if (cnt_reg != 32'h0) begin
      cnt_next = cnt_reg - 32'h1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign pulse_out = (cnt_reg != 32'h0);

  a_pulse_len: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    $rose(pulse_out) && !fire_in |-> pulse_out [*8])
    else $error("pulse shorter than eight cycles");
endmodule : ctp_pulse

//--- hw/ctp_regs.sv
// timer, thermistor and overvoltage control registers with shutdown logic
//
// Overview of operation
// - slow-down bit halves timer rate during any regulation loop
// - limit 00=0.75h, 01=6h, 10=9h, 11=timers off
// - disconnect bit plus input removed opens battery switch
// - thermistor enable defaults 1; zero disables monitoring
// - state field 000 normal, 001 hot, 010 warm, 011 cool, 100 cold
// - 101 freeze-to-cold, 110 below freeze, 111 open or disabled
// - overvoltage code 000..111 selects 6.0V..10.5V, reset 111
// - release bit 1 turns D+ source off, 0 keeps it on
// - detection runs on termination, test force, or force bit
// - test mode bit enters production test, no input limit
// - test mode refused when a battery is already present
// - die over threshold suspends charge, converter and timers
// - shutdown entry gives 256 us pulse on status and interrupt
// - new charge only after die cools about 10 C below
// - fault code 0110 shutdown, 0111 timer expiry
`timescale 1ns/1ps
module ctp_regs
  import ctp_pkg::*;
#(
  parameter longint unsigned MIN_CYC = CTP_CYC_PER_MIN
) (
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       input_present_in,
  input  wire ctp_loops_t loops_in,
  input  wire logic [2:0] thermistor_state_in,
  input  wire logic       battery_present_in,
  input  wire logic       termination_in,
  input  wire logic       die_over_shutdown_in,
  input  wire logic       die_below_restart_in,
  input  wire logic       charge_start_in,
  output logic            charge_enable_out,
  output logic            converter_enable_out,
  output logic            battery_switch_on_out,
  output logic            thermistor_monitor_out,
  output logic      [2:0] input_overvoltage_level_out,
  output logic            dplus_source_on_out,
  output logic            battery_detect_run_out,
  output logic            production_test_mode_out,
  output logic            input_limit_disable_out,
  output logic      [3:0] fault_code_out,
  output logic            status_pulse_out,
  output logic            irq_pulse_out
);
  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [10:0] s1_reg;
  logic [10:0] s2_reg;
  logic [10:0] raw;
  assign raw = {input_present_in, loops_in, thermistor_state_in,
                battery_present_in, termination_in, die_over_shutdown_in,
                die_below_restart_in};
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s1_reg <= 11'h0;
      s2_reg <= 11'h0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end
  logic       in_ok;
  logic       loop_any;
  logic [2:0] th_raw;
  logic       bat_ok;
  logic       term_ok;
  logic       hot_die;
  logic       cool_die;
  assign in_ok    = s2_reg[10];
  assign loop_any = |s2_reg[9:7];
  assign th_raw   = s2_reg[6:4];
  assign bat_ok   = s2_reg[3];
  assign term_ok  = s2_reg[2];
  assign hot_die  = s2_reg[1];
  assign cool_die = s2_reg[0];

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] tmr_reg;
  logic [7:0] tmr_next;
  logic [7:0] ovp_reg;
  logic [7:0] ovp_next;
  logic       test_mode_reg;
  logic       test_mode_next;

  // write decode; thermistor state bits never stored
  always_comb begin
    tmr_next = tmr_reg;
    ovp_next = ovp_reg;
    test_mode_next = test_mode_reg;
    if (reg_wr_in && reg_addr_in == CTP_TMR_CTRL_ADDR) begin
      tmr_next = {reg_wdata_in[7:3], 3'h0};
    end else if (reg_wr_in && reg_addr_in == CTP_OVP_CTRL_ADDR) begin
      ovp_next = reg_wdata_in;
      // entry into test mode refused with battery present
      if (reg_wdata_in[CTP_TEST_BIT] && !test_mode_reg) begin
        test_mode_next = !bat_ok;
      end else if (!reg_wdata_in[CTP_TEST_BIT]) begin
        test_mode_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tmr_reg <= CTP_TMR_RESET;
      ovp_reg <= CTP_OVP_RESET;
      test_mode_reg <= 1'b0;
    end else begin
      tmr_reg <= tmr_next;
      ovp_reg <= ovp_next;
      test_mode_reg <= test_mode_next;
    end
  end

  // thermistor state shown; open code when monitoring off
  logic [2:0] th_state;
  assign th_state = tmr_reg[CTP_THEN_BIT] ? th_raw : CTP_TH_OPEN;

  // read mux
  always_comb begin
    if (reg_addr_in == CTP_TMR_CTRL_ADDR) begin
      reg_rdata_out = {tmr_reg[7:3], th_state};
    end else if (reg_addr_in == CTP_OVP_CTRL_ADDR) begin
      reg_rdata_out = ovp_reg;
    end else begin
      reg_rdata_out = 8'h0;
    end
  end

  // ************************************************************
  // thermal shutdown state machine
  // ************************************************************
  typedef enum logic [0:0] {CTP_RUN, CTP_SHUT} ctp_state_t;
  ctp_state_t st_reg;
  ctp_state_t st_next;
  logic       fire;
  always_comb begin
    st_next = st_reg;
    fire    = 1'b0;
    case (st_reg)
      CTP_RUN: begin
        if (hot_die) begin
          st_next = CTP_SHUT;
          fire    = 1'b1;
        end
      end
      CTP_SHUT: begin
        if (!hot_die && cool_die) begin
          st_next = CTP_RUN;
        end
      end
      default: st_next = CTP_RUN;
    endcase
  end
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_reg <= CTP_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  logic pulse;
  ctp_pulse #(
    .LEN (32'(CTP_PULSE_CYC))
  ) u_pulse (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .fire_in    (fire),
    .pulse_out  (pulse)
  );
  assign status_pulse_out = pulse;
  assign irq_pulse_out    = pulse;

  // ************************************************************
  // safety timer
  // ************************************************************
  logic [63:0] tick_reg;
  logic [63:0] tick_next;
  logic [9:0]  min_reg;
  logic [9:0]  min_next;
  logic        exp_reg;
  logic        exp_next;
  logic [9:0]  lim_min;
  logic [1:0]  lim_sel;
  logic [63:0] step_len;
  logic        shut;
  assign shut    = (st_reg == CTP_SHUT);
  assign lim_sel = tmr_reg[CTP_LIM_HI:CTP_LIM_LO];
  // limit decode in minutes
  always_comb begin
    case (lim_sel)
      CTP_LIM_075H: lim_min = 10'(CTP_T075_MIN);
      CTP_LIM_6H:   lim_min = 10'(CTP_T6_MIN);
      CTP_LIM_9H:   lim_min = 10'(CTP_T9_MIN);
      default:      lim_min = 10'h0;
    endcase
  end
  // a minute takes twice as long while slowed
  assign step_len = (tmr_reg[CTP_SLOW_BIT] && loop_any)
                    ? (MIN_CYC << 1) : MIN_CYC;
  always_comb begin
    tick_next = tick_reg;
    min_next  = min_reg;
    exp_next  = exp_reg;
    if (!charge_start_in || lim_sel == CTP_LIM_OFF) begin
      tick_next = 64'h0;
      min_next  = 10'h0;
      exp_next  = 1'b0;
    end else if (!shut && !exp_reg) begin
      if (tick_reg + 64'h1 >= step_len) begin
        tick_next = 64'h0;
        min_next  = min_reg + 10'h1;
        if (min_reg + 10'h1 >= lim_min) begin
          exp_next = 1'b1;
        end
      end else begin
        tick_next = tick_reg + 64'h1;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tick_reg <= 64'h0;
      min_reg  <= 10'h0;
      exp_reg  <= 1'b0;
    end else begin
      tick_reg <= tick_next;
      min_reg  <= min_next;
      exp_reg  <= exp_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign fault_code_out = shut ? CTP_FAULT_TSHUT
                        : (exp_reg ? CTP_FAULT_TIMER : CTP_FAULT_NONE);
  assign charge_enable_out      = charge_start_in && !shut && !exp_reg;
  assign converter_enable_out   = !shut;
  assign battery_switch_on_out  = !(tmr_reg[CTP_DISC_BIT] && !in_ok);
  assign thermistor_monitor_out = tmr_reg[CTP_THEN_BIT];
  assign input_overvoltage_level_out = ovp_reg[CTP_OVP_HI:CTP_OVP_LO];
  assign dplus_source_on_out    = !ovp_reg[CTP_DPREL_BIT];
  assign battery_detect_run_out = ovp_reg[CTP_BDET_BIT] || term_ok
                                  || test_mode_reg;
  assign production_test_mode_out = test_mode_reg;
  assign input_limit_disable_out  = test_mode_reg;

  // checks on shutdown, timer and register behaviour
  default clocking cb_chk @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  a_shut_pulse: assert property (
    $rose(shut) |-> status_pulse_out && irq_pulse_out)
    else $error("no pulse on shutdown entry");
  a_shut_fault: assert property (
    shut |-> fault_code_out == CTP_FAULT_TSHUT && !converter_enable_out)
    else $error("shutdown not reflected");
  a_test_refuse: assert property (
    reg_wr_in && reg_addr_in == 8'h06 && reg_wdata_in[2] && bat_ok
    && !test_mode_reg |=> !production_test_mode_out)
    else $error("test mode entered with battery");
  a_th_read: assert property (
    reg_addr_in == CTP_TMR_CTRL_ADDR && tmr_reg[CTP_THEN_BIT]
    |-> reg_rdata_out[2:0] == th_raw)
    else $error("thermistor state not shown");
  a_disc_sw: assert property (
    tmr_reg[4] && !in_ok |-> !battery_switch_on_out)
    else $error("battery switch stays on");
  a_timer_hold: assert property (
    shut && charge_start_in && lim_sel != 2'h3 |=> $stable(min_reg))
    else $error("timer ran in shutdown");
  a_exp_code: assert property (
    exp_reg && !shut |-> fault_code_out == 4'h7)
    else $error("timer fault code wrong");
  a_restart_cool: assert property (
    $fell(shut) |-> $past(cool_die))
    else $error("restart before cooling");
endmodule : ctp_regs

//--- verification/ctp_host_model.sv
// host model driving the register port and the charge request
`timescale 1ns/1ps
module ctp_host_model
  import ctp_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic [7:0] reg_rdata_in,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_wr_out,
  output logic            charge_start_out
);
  // idle bus at time zero
  initial begin
    reg_addr_out     = 8'h00;
    reg_wdata_out    = 8'h00;
    reg_wr_out       = 1'b0;
    charge_start_out = 1'b0;
  end
  // one write strobe; data inverted once released
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    reg_addr_out  = a;
    reg_wdata_out = (a == CTP_OVP_CTRL_ADDR) ? (d & 8'hfc) : d;
    reg_wr_out    = 1'b1;
    @(negedge clock_in);
    reg_wr_out    = 1'b0;
    reg_wdata_out = ~reg_wdata_out;
  endtask : write
  // combinational read sampled mid-cycle
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_in);
    reg_addr_out = a;
    #10;
    d = reg_rdata_in;
  endtask : read
  // charge enable toggle restarts charging after a timer fault
  task automatic restart();
    @(negedge clock_in);
    charge_start_out = 1'b0;
    @(negedge clock_in);
    charge_start_out = 1'b1;
  endtask : restart
endmodule : ctp_host_model

//--- verification/test_ctp_regs.sv
// self-checking bench for the timer, thermistor and overvoltage registers
`timescale 1ns/1ps
`define CHK(g, e) check(g, e)
module test_ctp_regs
  import ctp_pkg::*;
;
  // ****
  // signals and instances
  // ****
  localparam longint unsigned MINC = 10;
  logic       clock_in, sys_rst_in, wr, start, inp, bat, term, over, below;
  logic [7:0] addr, wdata, rdata, d;
  logic [2:0] th_in, ovp;
  logic [3:0] fault;
  logic       ce, conv, bsw, tmon, dpl, bdet, tmode, nolim, stp, irq;
  ctp_loops_t loops;
  int         error_cnt = 0;
  int         n_compared = 0;

  ctp_regs #(.MIN_CYC(MINC)) u_dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rdata_out(rdata),
    .input_present_in(inp), .loops_in(loops), .thermistor_state_in(th_in),
    .battery_present_in(bat), .termination_in(term),
    .die_over_shutdown_in(over), .die_below_restart_in(below),
    .charge_start_in(start), .charge_enable_out(ce),
    .converter_enable_out(conv), .battery_switch_on_out(bsw),
    .thermistor_monitor_out(tmon), .input_overvoltage_level_out(ovp),
    .dplus_source_on_out(dpl), .battery_detect_run_out(bdet),
    .production_test_mode_out(tmode), .input_limit_disable_out(nolim),
    .fault_code_out(fault), .status_pulse_out(stp), .irq_pulse_out(irq));
  ctp_host_model u_host (
    .clock_in(clock_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_wr_out(wr), .charge_start_out(start));

  // ****
  // helpers
  // ****
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask : cyc
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // ****
  // scenarios
  // ****
  // power-on values and an unmapped read
  task automatic t_reset();
    u_host.read(CTP_TMR_CTRL_ADDR, d);
    `CHK(d, CTP_TMR_RESET);
    u_host.read(CTP_OVP_CTRL_ADDR, d);
    `CHK(d, CTP_OVP_RESET);
    u_host.read(8'h07, d);
    `CHK(d, 8'h00);
    `CHK({tmon, ovp, dpl, tmode}, 6'h3e);
  endtask : t_reset
  // every thermistor code, read-only field, monitor disable
  task automatic t_therm();
    for (int s = 0; s < 8; s++) begin
      th_in = s[2:0];
      cyc(4);
      u_host.read(CTP_TMR_CTRL_ADDR, d);
      `CHK(d[2:0], s[2:0]);
    end
    th_in = 3'h2;
    u_host.write(CTP_TMR_CTRL_ADDR, 8'hbd);
    cyc(4);
    u_host.read(CTP_TMR_CTRL_ADDR, d);
    `CHK(d, 8'hba);
    u_host.write(CTP_TMR_CTRL_ADDR, 8'hb0);
    u_host.read(CTP_TMR_CTRL_ADDR, d);
    `CHK({tmon, d}, 9'h0b7);
    u_host.write(CTP_TMR_CTRL_ADDR, 8'hb8);
  endtask : t_therm
  // overvoltage codes and D+ release
  task automatic t_ovp();
    for (int v = 0; v < 8; v++) begin
      u_host.write(CTP_OVP_CTRL_ADDR, {v[2:0], 5'h00});
      `CHK(ovp, v[2:0]);
    end
    u_host.write(CTP_OVP_CTRL_ADDR, 8'h10);
    `CHK(dpl, 1'b0);
    u_host.write(CTP_OVP_CTRL_ADDR, 8'he0);
    `CHK(dpl, 1'b1);
  endtask : t_ovp
  // test mode refusal and entry, battery detection causes
  task automatic t_test();
    bat = 1'b1;
    cyc(4);
    u_host.write(CTP_OVP_CTRL_ADDR, 8'he4);
    `CHK(tmode, 1'b0);
    bat = 1'b0;
    cyc(4);
    u_host.write(CTP_OVP_CTRL_ADDR, 8'he0);
    u_host.write(CTP_OVP_CTRL_ADDR, 8'he4);
    `CHK({tmode, nolim, bdet}, 3'h7);
    u_host.write(CTP_OVP_CTRL_ADDR, 8'he0);
    `CHK({tmode, bdet}, 2'h0);
    term = 1'b1;
    cyc(4);
    `CHK(bdet, 1'b1);
    term = 1'b0;
    cyc(4);
    u_host.write(CTP_OVP_CTRL_ADDR, 8'he8);
    `CHK(bdet, 1'b1);
    u_host.write(CTP_OVP_CTRL_ADDR, 8'he0);
  endtask : t_test
  // battery switch opens only with the bit set and input gone
  task automatic t_disc();
    inp = 1'b0;
    cyc(4);
    `CHK(bsw, 1'b0);
    u_host.write(CTP_TMR_CTRL_ADDR, 8'ha8);
    `CHK(bsw, 1'b1);
    inp = 1'b1;
    u_host.write(CTP_TMR_CTRL_ADDR, 8'hb8);
    cyc(4);
    `CHK(bsw, 1'b1);
  endtask : t_disc
  // limits, slow-down with each loop, disabled timer
  task automatic t_timer();
    logic [1:0] lim [8] = '{0, 1, 2, 0, 0, 0, 0, 3};
    logic       slw [8] = '{0, 0, 0, 1, 1, 1, 0, 0};
    logic [2:0] lp  [8] = '{0, 0, 0, 3'h4, 3'h1, 3'h2, 3'h4, 0};
    int         e, n;
    for (int i = 0; i < 8; i++) begin
      e = (lim[i] == CTP_LIM_075H) ? CTP_T075_MIN :
          (lim[i] == CTP_LIM_6H) ? CTP_T6_MIN : CTP_T9_MIN;
      e = e * MINC * ((slw[i] && lp[i] != 0) ? 2 : 1);
      u_host.write(CTP_TMR_CTRL_ADDR, {slw[i], lim[i], 5'h08});
      loops = lp[i];
      cyc(4);
      u_host.restart();
      n = 0;
      while (fault !== CTP_FAULT_TIMER && n < 6000) begin
        cyc(1);
        n++;
      end
      if (lim[i] == CTP_LIM_OFF) `CHK(n, 6000);
      else `CHK({(n >= e - 4) && (n <= e + 8), ce}, 2'h2);
    end
    loops = 3'h0;
  endtask : t_timer
  // shutdown entry, pulse length, restart after cooling
  task automatic t_shut();
    int n;
    u_host.write(CTP_TMR_CTRL_ADDR, 8'h98); // short limit, trips unless paused
    `CHK({conv, ce}, 2'h3);
    over = 1'b1;
    for (n = 0; n < 10 && stp !== 1'b1; n++) cyc(1);
    `CHK({fault, conv, ce}, {CTP_FAULT_TSHUT, 2'h0});
    n = 0;
    while (stp === 1'b1 && n < 3000) begin
      `CHK(irq, 1'b1);
      cyc(1);
      n++;
    end
    `CHK(n, CTP_PULSE_CYC);
    over = 1'b0;
    cyc(10);
    `CHK(conv, 1'b0);
    below = 1'b1;
    cyc(10);
    `CHK({conv, fault}, {1'b1, CTP_FAULT_NONE});
  endtask : t_shut

  // main sequence
  initial begin
    sys_rst_in = 1'b1;
    {inp, bat, term, over, below} = 5'h10;
    th_in = 3'h0;
    loops = 3'h0;
    cyc(16);
    sys_rst_in = 1'b0;
    cyc(3);
    t_reset();
    $display("reset test done");
    t_therm();
    $display("thermistor test done");
    t_ovp();
    $display("overvoltage test done");
    t_test();
    $display("test mode test done");
    t_disc();
    $display("disconnect test done");
    t_timer();
    $display("timer test done");
    t_shut();
    $display("shutdown test done");
    end_sim();
  end
endmodule : test_ctp_regs
